/* shared/bbl_defs.vh */
// constants for the bridge bus number and latency configuration block
// Summary of operation
// - The primary hold value is writable and sets the cycles from frame start to timer expiry.
// - A zero primary hold value makes the bridge leave the bus after one transfer once grant goes.
// - The header layout byte is read-only and reads 0x01 whenever its lane 2 is enabled.
// - Config dwords 10h to 3Fh are decoded in the bridge header layout.
// - The upstream bus id steers secondary type 1 cycles into special cycles or upstream forwarding.
// - The downstream bus id steers claiming and type 0 or special conversion of primary type 1 cycles.
// - The highest behind bus id holds the top bus number behind the bridge.
// - Primary type 1 cycles above the downstream bus id up to the highest behind bus id pass down as type 1.
// - The secondary hold value is writable and sets the cycles from frame start to timer expiry.
// - A zero secondary hold value ends the transaction after one transfer once grant goes.
// - Dword 0x0C has the primary hold value in lane 1 and the header layout in lane 2.
// - Dword 0x18 holds upstream, downstream, highest bus ids and secondary hold value in lanes 0-3.
// - A line size that is not a power of two or above 16 acts as 16 dwords for write and invalidate.
`ifndef BBL_DEFS_VH
`define BBL_DEFS_VH
// config dword byte addresses
`define BBL_DW_LINE_HDR 8'h0C
`define BBL_DW_BUS_IDS 8'h18
`define BBL_HDR_LO 8'h10
`define BBL_HDR_HI 8'h3F
// field positions
`define BBL_LANE0 7:0
`define BBL_LANE1 15:8
`define BBL_LANE2 23:16
`define BBL_LANE3 31:24
// reset and fixed values
`define BBL_HDR_TYPE 8'h01
`define BBL_RST_BYTE 8'h00
`define BBL_ZERO_DW 32'h0000_0000
`define BBL_LINE_MAX 8'h10
`define BBL_LINE_DEF 5'h10
// special cycle encoding of a type 1 address
`define BBL_SPC_DEV 5'h1F
`define BBL_SPC_FUNC 3'h7
`define BBL_SPC_REG 6'h00
`endif

/* core/bbl_hold_timer.v */
// master latency timer and release decision for one bus side
`include "bbl_defs.vh"
module bbl_hold_timer (
  // clock and reset
  input wire clk,
  input wire reset,
  // programmed values
  input wire [7:0] hold_value,
  input wire [4:0] line_dwords,
  // own master state
  input wire frame_start,
  input wire data_xfer,
  input wire mwi,
  input wire gnt_n_sync,
  // results
  output wire expired,
  output reg release_pulse
);
  reg [7:0] count_reg;
  reg active_reg;
  reg [4:0] line_cnt_reg;
  wire boundary;

  // reload at frame start, then one step per clock down to zero
  always @(posedge clk) begin
    if (reset) begin
      count_reg <= `BBL_RST_BYTE;
      active_reg <= 1'b0;
    end else if (frame_start) begin
      count_reg <= hold_value;
      active_reg <= 1'b1;
    end else begin
      if (count_reg != `BBL_RST_BYTE) begin
        count_reg <= count_reg - 8'h01;
      end
      if (release_pulse) begin
        active_reg <= 1'b0;
      end
    end
  end

  // zero value means expired from the frame start on
  assign expired = active_reg && (count_reg == `BBL_RST_BYTE);

  // dword position inside the cache line for write and invalidate
  always @(posedge clk) begin
    if (reset || frame_start) begin
      line_cnt_reg <= 5'h00;
    end else if (data_xfer) begin
      line_cnt_reg <= boundary ? 5'h00 : line_cnt_reg + 5'h01;
    end
  end
  assign boundary = (line_cnt_reg + 5'h01) == line_dwords;

  // leave after a transfer only once grant is gone; mwi waits for a line end
  always @(posedge clk) begin
    if (reset) begin
      release_pulse <= 1'b0;
    end else begin
      release_pulse <= data_xfer && expired && gnt_n_sync && (!mwi || boundary);
    end
  end
endmodule // bbl_hold_timer

/* core/bbl_type1_route.v */
// routing decision for one direction of type 1 configuration cycles
`include "bbl_defs.vh"
module bbl_type1_route #(
  parameter UPSTREAM = 0
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // decoded cycle
  input wire valid,
  input wire [7:0] bus,
  input wire special_enc,
  // bus ids
  input wire [7:0] pri_id,
  input wire [7:0] sec_id,
  input wire [7:0] sub_id,
  // decision
  output reg done,
  output reg claim,
  output reg to_type0,
  output reg to_special,
  output reg keep_type1
);
  wire behind;
  wire here;
  assign behind = (bus >= sec_id) && (bus <= sub_id);
  assign here = UPSTREAM ? (bus == pri_id) : (bus == sec_id);

  // one registered answer per valid request
  always @(posedge clk) begin
    if (reset) begin
      done <= 1'b0;
      claim <= 1'b0;
      to_type0 <= 1'b0;
      to_special <= 1'b0;
      keep_type1 <= 1'b0;
    end else begin
      done <= valid;
      if (UPSTREAM) begin
        // special cycles for our own primary bus, else anything not behind us goes up
        to_type0 <= 1'b0;
        to_special <= valid && here && special_enc;
        keep_type1 <= valid && !behind && !(here && special_enc);
        claim <= valid && !behind;
      end else begin
        to_type0 <= valid && here && !special_enc;
        to_special <= valid && here && special_enc;
        keep_type1 <= valid && behind && !here;
        claim <= valid && behind;
      end
    end
  end
endmodule // bbl_type1_route

/* core/bbl_top.v */
// bus number and latency timer configuration registers of the bridge
`include "bbl_defs.vh"
module bbl_top (
  // clock and reset
  input wire clk,
  input wire reset,
  // configuration access from the primary side
  input wire cfg_req,
  input wire cfg_write,
  input wire [7:0] cfg_dword_addr,
  input wire [3:0] upstream_cmd_lane_enable_n,
  input wire [31:0] cfg_wdata,
  output reg cfg_ack,
  output reg [31:0] cfg_rdata,
  // primary master activity
  input wire pri_frame_start,
  input wire pri_data_xfer,
  input wire pri_mwi,
  input wire upstream_gnt_n,
  output wire pri_timer_expired,
  output wire pri_release,
  // secondary master activity
  input wire sec_frame_start,
  input wire sec_data_xfer,
  input wire sec_mwi,
  input wire downstream_gnt_n,
  output wire sec_timer_expired,
  output wire sec_release,
  // type 1 cycle seen on the primary side
  input wire pri_cfg1_valid,
  input wire [7:0] pri_cfg1_bus,
  input wire [4:0] pri_cfg1_dev,
  input wire [2:0] pri_cfg1_func,
  input wire [5:0] pri_cfg1_reg,
  output wire pri_route_done,
  output wire pri_claim,
  output wire sec_out_type0,
  output wire sec_out_special,
  output wire sec_out_type1,
  // type 1 cycle seen on the secondary side
  input wire sec_cfg1_valid,
  input wire [7:0] sec_cfg1_bus,
  input wire [4:0] sec_cfg1_dev,
  input wire [2:0] sec_cfg1_func,
  input wire [5:0] sec_cfg1_reg,
  output wire sec_route_done,
  output wire sec_claim,
  output wire pri_out_special,
  output wire pri_out_type1,
  // programmed bus ids for the rest of the bridge
  output wire [7:0] upstream_bus_id,
  output wire [7:0] downstream_bus_id,
  output wire [7:0] highest_behind_bus_id
);

  // register state
  reg [7:0] line_size_reg;
  reg [7:0] primary_master_hold_timer_reg;
  reg [7:0] upstream_bus_id_reg;
  reg [7:0] downstream_bus_id_reg;
  reg [7:0] highest_behind_bus_id_reg;
  reg [7:0] downstream_master_hold_timer_reg;

  // grant pin synchronisers
  reg pri_gnt_meta_reg;
  reg pri_gnt_sync_reg;
  reg sec_gnt_meta_reg;
  reg sec_gnt_sync_reg;

  // access decode
  wire hit_line_hdr;
  wire hit_bus_ids;
  wire do_write;
  wire [3:0] lane_en;
  wire [4:0] line_dwords;
  wire in_hdr_range;
  reg [31:0] rdata_next;
  // decoded special cycles of both directions
  wire pri_special;
  wire sec_special;

  // true when the lane is selected; lane enables are active low on the bus
  function lane_on;
    input [3:0] en_n;
    input [1:0] lane;
    begin
      lane_on = !en_n[lane];
    end
  endfunction

  // line size used for write and invalidate; zero, non power of two or oversized values fall to 16
  function [4:0] eff_line;
    input [7:0] size;
    begin
      if ((size == `BBL_RST_BYTE) || (size > `BBL_LINE_MAX) ||
          ((size & (size - 8'h01)) != `BBL_RST_BYTE)) begin
        eff_line = `BBL_LINE_DEF;
      end else begin
        eff_line = size[4:0];
      end
    end
  endfunction

  // special cycle encoding of a type 1 address
  function is_special;
    input [4:0] dev;
    input [2:0] func;
    input [5:0] regn;
    begin
      is_special = (dev == `BBL_SPC_DEV) && (func == `BBL_SPC_FUNC) &&
                   (regn == `BBL_SPC_REG);
    end
  endfunction

  // header layout decode of the 10h to 3Fh range picks the bus id dword 0x18; dword 0x0C is decoded on its own
  assign hit_line_hdr = (cfg_dword_addr == `BBL_DW_LINE_HDR);
  assign in_hdr_range = (cfg_dword_addr >= `BBL_HDR_LO) && (cfg_dword_addr <= `BBL_HDR_HI);
  assign hit_bus_ids = in_hdr_range && (cfg_dword_addr == `BBL_DW_BUS_IDS);
  assign do_write = cfg_req && cfg_write;

  // byte lane selects, bit n is lane n
  assign lane_en[0] = lane_on(upstream_cmd_lane_enable_n, 2'h0);
  assign lane_en[1] = lane_on(upstream_cmd_lane_enable_n, 2'h1);
  assign lane_en[2] = lane_on(upstream_cmd_lane_enable_n, 2'h2);
  assign lane_en[3] = lane_on(upstream_cmd_lane_enable_n, 2'h3);

  // one effective line size serves both timers, as there is one line size register
  assign line_dwords = eff_line(line_size_reg);

  // special cycle decode of both incoming type 1 cycles
  assign pri_special = is_special(pri_cfg1_dev, pri_cfg1_func, pri_cfg1_reg);
  assign sec_special = is_special(sec_cfg1_dev, sec_cfg1_func, sec_cfg1_reg);

  // grant arrives from the arbiter pin, so two flops before any use
  always @(posedge clk) begin
    if (reset) begin
      pri_gnt_meta_reg <= 1'b1;
      pri_gnt_sync_reg <= 1'b1;
      sec_gnt_meta_reg <= 1'b1;
      sec_gnt_sync_reg <= 1'b1;
    end else begin
      pri_gnt_meta_reg <= upstream_gnt_n;
      pri_gnt_sync_reg <= pri_gnt_meta_reg;
      sec_gnt_meta_reg <= downstream_gnt_n;
      sec_gnt_sync_reg <= sec_gnt_meta_reg;
    end
  end

  // dword 0x0C writes: line size lane 0, primary hold value lane 1, lane 2 is fixed
  always @(posedge clk) begin
    if (reset) begin
      line_size_reg <= `BBL_RST_BYTE;
      primary_master_hold_timer_reg <= `BBL_RST_BYTE;
    end else if (do_write && hit_line_hdr) begin
      if (lane_en[0]) begin
        line_size_reg <= cfg_wdata[`BBL_LANE0];
      end
      if (lane_en[1]) begin
        primary_master_hold_timer_reg <= cfg_wdata[`BBL_LANE1];
      end
      // lane 2 is the fixed layout byte, so a write to it falls away
    end
  end

  // dword 0x18 writes, one byte per lane; ids reset to zero until software sets them
  always @(posedge clk) begin
    if (reset) begin
      upstream_bus_id_reg <= `BBL_RST_BYTE;
      downstream_bus_id_reg <= `BBL_RST_BYTE;
      highest_behind_bus_id_reg <= `BBL_RST_BYTE;
      downstream_master_hold_timer_reg <= `BBL_RST_BYTE;
    end else if (do_write && hit_bus_ids) begin
      if (lane_en[0]) begin
        upstream_bus_id_reg <= cfg_wdata[`BBL_LANE0];
      end
      if (lane_en[1]) begin
        downstream_bus_id_reg <= cfg_wdata[`BBL_LANE1];
      end
      if (lane_en[2]) begin
        highest_behind_bus_id_reg <= cfg_wdata[`BBL_LANE2];
      end
      if (lane_en[3]) begin
        downstream_master_hold_timer_reg <= cfg_wdata[`BBL_LANE3];
      end
    end
  end

  // read data; disabled lanes and unmapped dwords read as zero
  always @* begin
    rdata_next = `BBL_ZERO_DW;
    if (hit_line_hdr) begin
      if (lane_en[0]) begin
        rdata_next[`BBL_LANE0] = line_size_reg;
      end
      if (lane_en[1]) begin
        rdata_next[`BBL_LANE1] = primary_master_hold_timer_reg;
      end
      if (lane_en[2]) begin
        rdata_next[`BBL_LANE2] = `BBL_HDR_TYPE;
      end
      // lane 3 of this dword has nothing behind it and reads zero
    end else if (hit_bus_ids) begin
      if (lane_en[0]) begin
        rdata_next[`BBL_LANE0] = upstream_bus_id_reg;
      end
      if (lane_en[1]) begin
        rdata_next[`BBL_LANE1] = downstream_bus_id_reg;
      end
      if (lane_en[2]) begin
        rdata_next[`BBL_LANE2] = highest_behind_bus_id_reg;
      end
      if (lane_en[3]) begin
        rdata_next[`BBL_LANE3] = downstream_master_hold_timer_reg;
      end
    end
  end

  // answer one cycle after the request; read data hold until the next read request
  always @(posedge clk) begin
    if (reset) begin
      cfg_ack <= 1'b0;
      cfg_rdata <= `BBL_ZERO_DW;
    end else begin
      cfg_ack <= cfg_req;
      if (cfg_req && !cfg_write) begin
        cfg_rdata <= rdata_next;
      end
    end
  end

  // primary side latency timer
  bbl_hold_timer u_pri_timer (
    .clk(clk),
    .reset(reset),
    .hold_value(primary_master_hold_timer_reg),
    .line_dwords(line_dwords),
    .frame_start(pri_frame_start),
    .data_xfer(pri_data_xfer),
    .mwi(pri_mwi),
    .gnt_n_sync(pri_gnt_sync_reg),
    .expired(pri_timer_expired),
    .release_pulse(pri_release)
  );

  // secondary side latency timer
  bbl_hold_timer u_sec_timer (
    .clk(clk),
    .reset(reset),
    .hold_value(downstream_master_hold_timer_reg),
    .line_dwords(line_dwords),
    .frame_start(sec_frame_start),
    .data_xfer(sec_data_xfer),
    .mwi(sec_mwi),
    .gnt_n_sync(sec_gnt_sync_reg),
    .expired(sec_timer_expired),
    .release_pulse(sec_release)
  );

  // primary type 1 cycles going downstream
  bbl_type1_route #(
    .UPSTREAM(0)
  ) u_down_route (
    .clk(clk),
    .reset(reset),
    .valid(pri_cfg1_valid),
    .bus(pri_cfg1_bus),
    .special_enc(pri_special),
    .pri_id(upstream_bus_id_reg),
    .sec_id(downstream_bus_id_reg),
    .sub_id(highest_behind_bus_id_reg),
    .done(pri_route_done),
    .claim(pri_claim),
    .to_type0(sec_out_type0),
    .to_special(sec_out_special),
    .keep_type1(sec_out_type1)
  );

  // secondary type 1 cycles going upstream; type 0 never leaves this way
  bbl_type1_route #(
    .UPSTREAM(1)
  ) u_up_route (
    .clk(clk),
    .reset(reset),
    .valid(sec_cfg1_valid),
    .bus(sec_cfg1_bus),
    .special_enc(sec_special),
    .pri_id(upstream_bus_id_reg),
    .sec_id(downstream_bus_id_reg),
    .sub_id(highest_behind_bus_id_reg),
    .done(sec_route_done),
    .claim(sec_claim),
    .to_type0(),
    .to_special(pri_out_special),
    .keep_type1(pri_out_type1)
  );

  // bus ids straight from their registers
  assign upstream_bus_id = upstream_bus_id_reg;
  assign downstream_bus_id = downstream_bus_id_reg;
  assign highest_behind_bus_id = highest_behind_bus_id_reg;

endmodule // bbl_top

/* test/bbl_checker.sv */
// concurrent assertions on the ports of the bus number and latency block
module bbl_checker (
  // clock and reset
  input logic clk,
  input logic reset,
  // configuration port
  input logic cfg_req,
  input logic cfg_write,
  input logic [7:0] cfg_dword_addr,
  input logic [3:0] upstream_cmd_lane_enable_n,
  input logic cfg_ack,
  input logic [31:0] cfg_rdata,
  // type 1 routing
  input logic pri_cfg1_valid,
  input logic [7:0] pri_cfg1_bus,
  input logic pri_route_done,
  input logic pri_claim,
  input logic sec_out_type0,
  input logic sec_out_type1,
  input logic sec_cfg1_valid,
  input logic [7:0] sec_cfg1_bus,
  input logic pri_out_type1,
  input logic [7:0] upstream_bus_id,
  input logic [7:0] downstream_bus_id,
  input logic [7:0] highest_behind_bus_id,
  // master timers
  input logic pri_data_xfer,
  input logic pri_timer_expired,
  input logic pri_release,
  input logic sec_data_xfer,
  input logic sec_timer_expired,
  input logic sec_release
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // every access answers exactly one cycle later and never without cause
  ack_follows_req_a: assert property (cfg_req |=> cfg_ack) else $error("no ack");
  ack_has_cause_a: assert property (cfg_ack |-> $past(cfg_req)) else $error("stray ack");
  hdr_fixed_a: assert property (cfg_req && !cfg_write && cfg_dword_addr == 8'h0C
    && !upstream_cmd_lane_enable_n[2] |=> cfg_rdata[23:16] == 8'h01)
    else $error("header byte wrong");
  route_done_a: assert property (pri_cfg1_valid |=> pri_route_done) else $error("no done");
  down_type1_a: assert property (pri_cfg1_valid && pri_cfg1_bus > downstream_bus_id
    && pri_cfg1_bus <= highest_behind_bus_id |=> sec_out_type1 && pri_claim)
    else $error("type 1 not passed down");
  outside_range_a: assert property (pri_cfg1_valid && (pri_cfg1_bus < downstream_bus_id
    || pri_cfg1_bus > highest_behind_bus_id) |=> !pri_claim && !sec_out_type0 && !sec_out_type1)
    else $error("claimed outside range");
  up_type1_a: assert property (sec_cfg1_valid && sec_cfg1_bus != upstream_bus_id
    && (sec_cfg1_bus < downstream_bus_id || sec_cfg1_bus > highest_behind_bus_id)
    |=> pri_out_type1) else $error("not forwarded upstream");
  pri_release_cause_a: assert property (pri_release
    |-> $past(pri_data_xfer && pri_timer_expired)) else $error("primary release without cause");
  sec_release_cause_a: assert property (sec_release
    |-> $past(sec_data_xfer && sec_timer_expired)) else $error("secondary release without cause");
endmodule // bbl_checker

bind bbl_top bbl_checker chk (.*);

/* test/bbl_arb_model.sv */
// bus arbiter model that grants or withdraws the bridge on both buses
module bbl_arb_model (
  // clock and reset
  input logic clk,
  input logic reset,
  // grant wishes from the bench, bit 0 primary, bit 1 secondary
  input logic [1:0] want,
  output logic [1:0] gnt_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // grant pins are active low and park released during reset
  always @(posedge clk) begin
    if (reset)
      gnt_n <= 2'b11;
    else
      gnt_n <= ~want;
  end
endmodule // bbl_arb_model

/* test/bbl_top_bench.sv */
// self-checking bench for the bus number and latency configuration block
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_mismatch++; \
  $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module bbl_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, reset = 1, cfg_req = 0, cfg_write = 0, pv = 0, sv = 0;
  logic [7:0] addr = 8'h00, rb = 8'h00;
  logic [3:0] en_n = 4'hF;
  logic [31:0] wdata = 32'h0;
  logic [1:0] fs = 2'h0, dx = 2'h0, mw = 2'h0, want = 2'h3;
  logic [4:0] rdev = 5'h00;
  logic [2:0] rfn = 3'h0;
  logic [5:0] rreg = 6'h00;
  wire cfg_ack, prd, pcl, t0, tsp, t1, srd, scl, psp, pt1;
  wire [31:0] cfg_rdata;
  wire [7:0] ub, db, hb;
  wire [1:0] gnt_n, exp_w, rel_w;
  int n_mismatch = 0, compares = 0;
  // clock
  initial begin
    forever #50 clk = ~clk;
  end
  bbl_arb_model arb (.clk(clk), .reset(reset), .want(want), .gnt_n(gnt_n));
  bbl_top DUT (.clk(clk), .reset(reset), .cfg_req(cfg_req), .cfg_write(cfg_write),
    .cfg_dword_addr(addr), .upstream_cmd_lane_enable_n(en_n), .cfg_wdata(wdata),
    .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .pri_frame_start(fs[0]), .pri_data_xfer(dx[0]),
    .pri_mwi(mw[0]), .upstream_gnt_n(gnt_n[0]), .pri_timer_expired(exp_w[0]),
    .pri_release(rel_w[0]), .sec_frame_start(fs[1]), .sec_data_xfer(dx[1]), .sec_mwi(mw[1]),
    .downstream_gnt_n(gnt_n[1]), .sec_timer_expired(exp_w[1]), .sec_release(rel_w[1]),
    .pri_cfg1_valid(pv), .pri_cfg1_bus(rb), .pri_cfg1_dev(rdev), .pri_cfg1_func(rfn),
    .pri_cfg1_reg(rreg), .pri_route_done(prd), .pri_claim(pcl), .sec_out_type0(t0),
    .sec_out_special(tsp), .sec_out_type1(t1), .sec_cfg1_valid(sv), .sec_cfg1_bus(rb),
    .sec_cfg1_dev(rdev), .sec_cfg1_func(rfn), .sec_cfg1_reg(rreg), .sec_route_done(srd),
    .sec_claim(scl), .pri_out_special(psp), .pri_out_type1(pt1), .upstream_bus_id(ub),
    .downstream_bus_id(db), .highest_behind_bus_id(hb));
  // one config access; ack is looked at in its only cycle
  task automatic cfg(input logic w, input logic [7:0] a, input logic [3:0] be,
    input logic [31:0] d);
    @(posedge clk);
    cfg_req <= 1'b1;
    cfg_write <= w;
    addr <= a;
    en_n <= be;
    wdata <= d;
    @(posedge clk);
    cfg_req <= 1'b0;
    #1;
    `CHK(cfg_ack, 1'b1)
  endtask
  task automatic t_regs;
    cfg(0, 8'h0C, 4'h0, 0);
    `CHK(cfg_rdata, 32'h0001_0000)
    cfg(0, 8'h18, 4'h0, 0);
    `CHK(cfg_rdata, 32'h0)
    cfg(1, 8'h0C, 4'h0, 32'hFFFF_FFFF);
    cfg(0, 8'h0C, 4'h0, 0);
    `CHK(cfg_rdata, 32'h0001_FFFF)
    cfg(1, 8'h18, 4'h0, 32'h0005_0301);
    cfg(1, 8'h18, 4'h7, 32'h07EE_EEEE);
    cfg(0, 8'h18, 4'h0, 0);
    `CHK(cfg_rdata, 32'h0705_0301)
    `CHK({ub, db, hb}, 24'h010305)
    cfg(1, 8'h10, 4'h0, 32'hFFFF_FFFF);
    cfg(0, 8'h10, 4'h0, 0);
    `CHK(cfg_rdata, 32'h0)
  endtask
  // ids are 1, 3 and 5 here; bus numbers 0 to 7, both encodings and a near miss go through
  task automatic t_route;
    logic [8:0] e;
    logic in_r, usp;
    for (int b = 0; b < 8; b++) begin
      for (int sp = 0; sp < 3; sp++) begin
        @(posedge clk);
        pv <= 1'b1;
        sv <= 1'b1;
        rb <= b[7:0];
        rdev <= sp ? 5'h1F : 5'h02;
        rfn <= sp ? 3'h7 : 3'h0;
        rreg <= (sp == 2) ? 6'h01 : 6'h00;
        @(posedge clk);
        pv <= 1'b0;
        sv <= 1'b0;
        #1;
        in_r = b >= 3 && b <= 5;
        usp = b == 1 && sp == 1;
        e = {2'b11, in_r, b == 3 && sp != 1, b == 3 && sp == 1, b > 3 && in_r,
          usp || !in_r, usp, !usp && !in_r};
        `CHK({prd, srd, pcl, t0, tsp, t1, scl, psp, pt1}, e)
      end
    end
  endtask
  // side s, hold value v, grant kept g, write and invalidate m
  task automatic t_timer(input int s, input logic [7:0] v, input logic g, input logic m);
    int n;
    cfg(1, s ? 8'h18 : 8'h0C, s ? 4'h7 : 4'hD, {4{v}});
    want[s] <= g;
    repeat (4) @(posedge clk);
    fs[s] <= 1'b1;
    @(posedge clk);
    fs[s] <= 1'b0;
    #1;
    n = 0;
    while (exp_w[s] !== 1'b1 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK(n, int'(v))
    @(posedge clk);
    dx[s] <= 1'b1;
    mw[s] <= m;
    @(posedge clk);
    dx[s] <= 1'b0;
    mw[s] <= 1'b0;
    #1;
    `CHK(rel_w[s], !g && !m)
    want[s] <= 1'b1;
  endtask
  // primary write and invalidate, hold value 0 and grant gone: a power of two
  // line size ends the burst at its line end, any other size acts as 16 dwords
  task automatic t_line(input logic [7:0] ls, input int k, input logic e);
    cfg(1, 8'h0C, 4'hE, {24'h00_0000, ls});
    want[0] <= 1'b0;
    repeat (4) @(posedge clk);
    fs[0] <= 1'b1;
    @(posedge clk);
    fs[0] <= 1'b0;
    dx[0] <= 1'b1;
    mw[0] <= 1'b1;
    for (int i = 1; i < k; i++) begin
      @(posedge clk);
      #1;
      `CHK(rel_w[0], 1'b0)
    end
    @(posedge clk);
    dx[0] <= 1'b0;
    mw[0] <= 1'b0;
    #1;
    `CHK(rel_w[0], e)
    want[0] <= 1'b1;
  endtask
  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog, well beyond the 150 or so cycles the scenarios need
  initial begin
    #(5000 * 100);
    n_mismatch++;
    stop_test();
  end
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_route();
    t_timer(0, 8'h05, 1'b0, 1'b0);
    t_timer(0, 8'h00, 1'b1, 1'b0);
    t_timer(1, 8'h00, 1'b0, 1'b0);
    t_timer(1, 8'h03, 1'b0, 1'b1);
    t_line(8'h02, 2, 1'b1);
    t_line(8'h03, 3, 1'b0);
    stop_test();
  end
endmodule // bbl_top_bench
